// [design/dcm_move_unit.sv]
// Contract
// - decode system read: opcode 010000, format 00001
// - 64-bit system register read copies full doubleword
// - 32-bit read, revision two up: zero upper
// - 32-bit below revision two: result undefined
// - decode system write: opcode 010000, format 00101
// - system write stores value, 32-bit keeps low (code: only from revision two up, below that full doubleword)
// - decode float read, copy register to destination
// - decode float write, store full doubleword
// - custom read passes 16-bit specifier unchanged
// - missing or 32-bit custom register: unpredictable
// - unusable coprocessor or disallowed move raises exception
// - 64-bit operations disabled raise reserved instruction
`timescale 1ns/1ps
module dcm_move_unit
  import dcm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic instr_valid,
  input wire logic [31:0] instr,
  input wire logic [63:0] gpr_rdata,
  input wire logic [2:0] isa_rev_level,
  input wire logic [2:0] cop_usable,
  input wire logic ops64_en,
  input wire logic move_permit,
  output logic busy_q,
  output logic wb_valid_q,
  output logic [4:0] wb_idx_q,
  output logic [63:0] wb_data_q,
  output logic exc_cu_q,
  output logic [1:0] exc_cop_q,
  output logic exc_ri_q,
  output logic [4:0] cp0_reg_q,
  output logic [2:0] cp0_sel_q,
  input wire logic [63:0] cp0_rdata,
  input wire logic cp0_is32,
  output logic cp0_we_q,
  output logic [63:0] cp0_wdata_q,
  output logic [4:0] fpr_addr_q,
  input wire logic [63:0] fpr_rdata,
  output logic fpr_we_q,
  output logic [63:0] fpr_wdata_q,
  output logic cp2_req_q,
  output logic [15:0] cp2_spec_q,
  input wire logic [63:0] cp2_rdata,
  input wire logic cp2_valid
);

  dcm_op_t dec_op;
  logic dec_zero_ok;
  logic [1:0] dec_cop;
  dcm_state_t state_q, state_d;
  logic is_wr_q;
  logic [63:0] gpr_q;

  dcm_decode u_dec (
    .instr(instr),
    .op(dec_op),
    .zero_ok(dec_zero_ok),
    .cop_num(dec_cop)
  );

  wire start = instr_valid && (state_q == S_IDLE) && (dec_op != OP_NONE);
  // pad so coprocessor number 3 still selects a defined bit
  wire [3:0] cop_use4 = {1'b0, cop_usable};
  wire cop_ok = cop_use4[dec_cop];
  wire fault_cu = !cop_ok;
  // disallowed move and disabled 64-bit ops share one trap
  wire fault_ri = cop_ok && (!ops64_en || !move_permit || !dec_zero_ok);
  wire go = start && !fault_cu && !fault_ri;
  // undefined below revision two: full value passes, no trap
  wire zero_fill = cp0_is32 && (isa_rev_level >= REV_ZERO_FILL);
  wire [63:0] sys_rd_val =
    zero_fill ? {UPPER_ZERO, cp0_rdata[31:0]} : cp0_rdata;
  wire [63:0] sys_wr_val =
    zero_fill ? {UPPER_ZERO, gpr_q[31:0]} : gpr_q;
  wire sys_done = (state_q == S_SYS);
  wire fpu_done = (state_q == S_FPU);
  // custom unit may take any number of cycles; core stays stalled
  wire cus_done = (state_q == S_CUS) && cp2_valid;
  wire rd_done = (sys_done && !is_wr_q) || fpu_done || cus_done;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      S_IDLE:
      begin
        if (go && (dec_op == OP_SYS_RD || dec_op == OP_SYS_WR))
          state_d = S_SYS;
        else if (go && dec_op == OP_FPU_RD)
          state_d = S_FPU;
        else if (go && dec_op == OP_CUS_RD)
          state_d = S_CUS;
      end
      S_SYS: state_d = S_IDLE;
      S_FPU: state_d = S_IDLE;
      S_CUS: state_d = cp2_valid ? S_IDLE : S_CUS;
      default: state_d = S_IDLE;
    endcase
  end

  wire busy_d = (state_d != S_IDLE);

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      state_q <= S_IDLE;
      busy_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      busy_q <= busy_d;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      is_wr_q <= 1'b0;
      gpr_q <= DWORD_RST;
      wb_idx_q <= 5'h00;
      cp0_reg_q <= 5'h00;
      cp0_sel_q <= 3'h0;
      fpr_addr_q <= 5'h00;
      cp2_spec_q <= 16'h0000;
    end
    else if (go)
    begin
      is_wr_q <= (dec_op == OP_SYS_WR);
      gpr_q <= gpr_rdata;
      wb_idx_q <= dcm_field5(instr, RT_LSB);
      cp0_reg_q <= dcm_field5(instr, RD_LSB);
      cp0_sel_q <= instr[SEL_LSB +: 3];
      fpr_addr_q <= dcm_field5(instr, RD_LSB);
      cp2_spec_q <= instr[SPEC_LSB +: 16];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      exc_cu_q <= 1'b0;
      exc_ri_q <= 1'b0;
      exc_cop_q <= 2'h0;
      cp2_req_q <= 1'b0;
      fpr_we_q <= 1'b0;
      fpr_wdata_q <= DWORD_RST;
    end
    else
    begin
      exc_cu_q <= start && fault_cu;
      exc_ri_q <= start && fault_ri;
      exc_cop_q <= start ? dec_cop : exc_cop_q;
      cp2_req_q <= go && (dec_op == OP_CUS_RD);
      fpr_we_q <= go && (dec_op == OP_FPU_WR);
      if (go && dec_op == OP_FPU_WR)
        fpr_wdata_q <= gpr_rdata;
    end
  end

  // destination width is only known once the address is out
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      cp0_we_q <= 1'b0;
      cp0_wdata_q <= DWORD_RST;
    end
    else
    begin
      cp0_we_q <= sys_done && is_wr_q;
      if (sys_done && is_wr_q)
        cp0_wdata_q <= sys_wr_val;
    end
  end

  // unknown custom registers give whatever the unit returns
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      wb_valid_q <= 1'b0;
      wb_data_q <= DWORD_RST;
    end
    else
    begin
      wb_valid_q <= rd_done;
      if (sys_done && !is_wr_q)
        wb_data_q <= sys_rd_val;
      else if (fpu_done)
        wb_data_q <= fpr_rdata;
      else if (cus_done)
        wb_data_q <= cp2_rdata;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  a_sys_rd_seq: assert property (go && dec_op == OP_SYS_RD |=>
    state_q == S_SYS ##1 wb_valid_q)
    else $error("system read did not write back in two cycles");
  a_full_copy: assert property (sys_done && !is_wr_q && !cp0_is32 |=>
    wb_data_q == $past(cp0_rdata))
    else $error("64-bit system read not copied whole");
  a_zero_fill: assert property (sys_done && !is_wr_q && zero_fill |=>
    wb_data_q[63:32] == UPPER_ZERO)
    else $error("upper half not cleared on 32-bit read");
  a_sys_wr_trunc: assert property (sys_done && is_wr_q && zero_fill |=>
    cp0_we_q && cp0_wdata_q == {UPPER_ZERO, gpr_q[31:0]})
    else $error("32-bit system write not truncated");
  a_sys_wr_seq: assert property (go && dec_op == OP_SYS_WR |=>
    !cp0_we_q ##1 cp0_we_q && !wb_valid_q)
    else $error("system write strobe mistimed");
  a_fpu_rd_data: assert property (go && dec_op == OP_FPU_RD |=>
    ##1 wb_valid_q && wb_data_q == $past(fpr_rdata))
    else $error("float read data wrong");
  a_fpu_wr_data: assert property (go && dec_op == OP_FPU_WR |=>
    fpr_we_q && fpr_wdata_q == $past(gpr_rdata) && !busy_q)
    else $error("float write data wrong");
  a_cp2_spec: assert property (go && dec_op == OP_CUS_RD |=>
    cp2_req_q && busy_q &&
    {16'h0000, cp2_spec_q} == ($past(instr) & 32'h0000_ffff))
    else $error("custom specifier not passed unchanged");
  a_cu_trap: assert property (start && fault_cu |=>
    exc_cu_q && !exc_ri_q && !busy_q && exc_cop_q == $past(dec_cop))
    else $error("unusable coprocessor not trapped");
  a_ri_64bit: assert property (start && cop_ok && !ops64_en |=>
    exc_ri_q && !cp2_req_q && !fpr_we_q && !busy_q)
    else $error("disabled 64-bit move not trapped");
  a_cp2_stall: assert property (state_q == S_CUS && !cp2_valid |=>
    !wb_valid_q && busy_q)
    else $error("write-back before custom valid");

endmodule

// [common/dcm_pkg.sv]
package dcm_pkg;

  localparam logic [5:0] OPC_SYS = 6'h10;
  localparam logic [5:0] OPC_FPU = 6'h11;
  localparam logic [5:0] OPC_CUS = 6'h12;
  localparam logic [4:0] FMT_MOVE_FROM = 5'h01;
  localparam logic [4:0] FMT_MOVE_TO = 5'h05;

  localparam int OPC_LSB = 26;
  localparam int FMT_LSB = 21;
  localparam int RT_LSB = 16;
  localparam int RD_LSB = 11;
  localparam int SEL_LSB = 0;
  localparam int SPEC_LSB = 0;

  localparam logic [2:0] REV_ZERO_FILL = 3'h2;
  localparam logic [31:0] UPPER_ZERO = 32'h0000_0000;
  localparam logic [63:0] DWORD_RST = 64'h0;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_SYS_RD = 3'b001,
    OP_SYS_WR = 3'b010,
    OP_FPU_RD = 3'b011,
    OP_FPU_WR = 3'b100,
    OP_CUS_RD = 3'b101
  } dcm_op_t;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_SYS = 2'b01,
    S_FPU = 2'b10,
    S_CUS = 2'b11
  } dcm_state_t;

  function automatic logic [4:0] dcm_field5(input logic [31:0] ins,
                                            input int lsb);
    dcm_field5 = 5'(ins >> lsb);
  endfunction

endpackage

// [design/dcm_decode.sv]
`timescale 1ns/1ps
module dcm_decode
  import dcm_pkg::*;
(
  input wire logic [31:0] instr,
  output dcm_op_t op,
  output logic zero_ok,
  output logic [1:0] cop_num
);

  wire [5:0] opc = instr[31:OPC_LSB];
  wire [4:0] fmt = dcm_field5(instr, FMT_LSB);
  wire is_from = (fmt == FMT_MOVE_FROM);
  wire is_to = (fmt == FMT_MOVE_TO);
  wire sys_hit = (opc == OPC_SYS);
  wire fpu_hit = (opc == OPC_FPU);
  wire cus_hit = (opc == OPC_CUS);

  // system moves keep bits 10..3 clear, float reads keep 10..0 clear
  wire sys_zero = (instr[10:3] == 8'h00);
  wire fpu_zero = (instr[10:0] == 11'h000);

  assign op = (sys_hit && is_from) ? OP_SYS_RD :
              (sys_hit && is_to) ? OP_SYS_WR :
              (fpu_hit && is_from) ? OP_FPU_RD :
              (fpu_hit && is_to) ? OP_FPU_WR :
              (cus_hit && is_from) ? OP_CUS_RD :
              OP_NONE;
  assign zero_ok = sys_hit ? sys_zero : (fpu_hit && is_from) ? fpu_zero : 1'b1;
  assign cop_num = opc[1:0];

endmodule

// [tb/dcm_cop_model.sv]
`timescale 1ns/1ps
module dcm_cop_model
(
  input wire logic clk_sys,
  input wire logic [4:0] cp0_reg_q,
  input wire logic [2:0] cp0_sel_q,
  output logic [63:0] cp0_rdata,
  output logic cp0_is32,
  input wire logic cp0_we_q,
  input wire logic [63:0] cp0_wdata_q,
  input wire logic [4:0] fpr_addr_q,
  output logic [63:0] fpr_rdata,
  input wire logic fpr_we_q,
  input wire logic [63:0] fpr_wdata_q,
  input wire logic cp2_req_q,
  input wire logic [15:0] cp2_spec_q,
  output logic [63:0] cp2_rdata,
  output logic cp2_valid,
  input wire logic [3:0] cp2_wait
);
  logic [63:0] sys_mem [0:255];
  logic [63:0] fp_mem [0:31];
  logic [63:0] cp2_last = 64'h0;
  int cnt = 0;
  // odd register numbers stand for 32-bit registers
  assign cp0_is32 = cp0_reg_q[0];
  assign cp0_rdata = sys_mem[{cp0_reg_q, cp0_sel_q}];
  assign fpr_rdata = fp_mem[fpr_addr_q];
  // idle reply bus flips so stale data never looks valid
  assign cp2_rdata = cp2_valid ? cp2_last : ~cp2_last;
  initial
  begin
    // upper half garbage, a read must hide it
    sys_mem[{5'h09, 3'h0}] = 64'hffff_ffff_1234_5678;
  end
  always @(posedge clk_sys)
  begin
    if (cp0_we_q)
      sys_mem[{cp0_reg_q, cp0_sel_q}] <= cp0_wdata_q;
    if (fpr_we_q)
      fp_mem[fpr_addr_q] <= fpr_wdata_q;
    cp2_valid <= 1'b0;
    if (cp2_req_q)
      cnt <= int'(cp2_wait);
    else if (cnt > 0)
      cnt <= cnt - 1;
    // every specifier exists and is 64 bits wide
    if ((cp2_req_q && cp2_wait == 4'h0) || (!cp2_req_q && cnt == 1))
    begin
      cp2_valid <= 1'b1;
      cp2_last <= {4{cp2_spec_q}} ^ 64'h0123_4567_89ab_cdef;
    end
  end
endmodule

// [tb/testbench.sv]
`timescale 1ns/1ps
module testbench;
  import dcm_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic instr_valid = 1'b0;
  logic [31:0] instr = 32'h0;
  logic [63:0] gpr_rdata = 64'h0;
  logic [2:0] isa_rev_level = 3'h2;
  logic [2:0] cop_usable = 3'h7;
  logic ops64_en = 1'b1;
  logic move_permit = 1'b1;
  logic [3:0] cp2_wait = 4'h0;
  logic busy_q, wb_valid_q, exc_cu_q, exc_ri_q, cp0_we_q, fpr_we_q;
  logic cp2_req_q, cp0_is32, cp2_valid;
  logic [4:0] wb_idx_q, cp0_reg_q, fpr_addr_q, ev;
  logic [63:0] wb_data_q, cp0_rdata, cp0_wdata_q, fpr_rdata;
  logic [63:0] fpr_wdata_q, cp2_rdata, got;
  logic [1:0] exc_cop_q;
  logic [2:0] cp0_sel_q;
  logic [15:0] cp2_spec_q;
  int n_errors = 0;
  int tests_run = 0;
  dcm_move_unit i_dut (.*);
  dcm_cop_model i_cop (.*);
  always #10 clk_sys = ~clk_sys;

  function automatic logic [31:0] ins(input logic [5:0] o,
    input logic [4:0] f, t, d, input logic [10:0] lo);
    return {o, f, t, d, lo};
  endfunction

  task automatic chk(input string nm, input logic [63:0] seen, exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // offer one move, wait for its pulse; ev is {wb, cp0 we, fpr we, cu, ri}
  task automatic run(input logic [31:0] i, input logic [63:0] gv,
    input logic [4:0] e);
    int k;
    logic bz;
    @(negedge clk_sys);
    instr = i;
    gpr_rdata = gv;
    instr_valid = 1'b1;
    @(negedge clk_sys);
    instr_valid = 1'b0;
    gpr_rdata = ~gv;
    bz = busy_q;
    for (k = 0; k < 40 && (wb_valid_q | cp0_we_q | fpr_we_q | exc_cu_q
         | exc_ri_q) !== 1'b1; k++)
      @(negedge clk_sys);
    ev = {wb_valid_q, cp0_we_q, fpr_we_q, exc_cu_q, exc_ri_q};
    got = wb_data_q;
    chk("event", {59'h0, ev}, {59'h0, e});
    chk("busy", {63'h0, bz}, {63'h0, e[4] | e[3]});
    chk("busy end", {63'h0, busy_q}, 64'h0);
  endtask

  task automatic t_sys();
    // register 4 is written and read at sub_index one, the other registers at sub_index zero
    run(ins(OPC_SYS, FMT_MOVE_TO, 5'h3, 5'h4, 11'h1), 64'hdead_beef_0123_4567,
        5'h08);
    chk("cp0 wdata", cp0_wdata_q, 64'hdead_beef_0123_4567);
    run(ins(OPC_SYS, FMT_MOVE_FROM, 5'h7, 5'h4, 11'h1), 64'h0,
        5'h10);
    chk("sys rd", got, 64'hdead_beef_0123_4567);
    chk("wb idx", {59'h0, wb_idx_q}, 64'h7);
    run(ins(OPC_SYS, FMT_MOVE_TO, 5'h3, 5'h5, 11'h0), 64'h8765_4321_aaaa_5555,
        5'h08);
    chk("cp0 w32", cp0_wdata_q, 64'h0000_0000_aaaa_5555);
    run(ins(OPC_SYS, FMT_MOVE_FROM, 5'h9, 5'h9, 11'h0), 64'h0,
        5'h10);
    chk("sys rd32", got, 64'h0000_0000_1234_5678);
    // below revision two a 32-bit register sees the whole doubleword
    isa_rev_level = 3'h1;
    run(ins(OPC_SYS, FMT_MOVE_TO, 5'h3, 5'hb, 11'h0), 64'h8765_4321_aaaa_5555,
        5'h08);
    chk("cp0 w rev1", cp0_wdata_q, 64'h8765_4321_aaaa_5555);
    run(ins(OPC_SYS, FMT_MOVE_FROM, 5'h7, 5'hb, 11'h0), 64'h0,
        5'h10);
    chk("sys rd rev1", got, 64'h8765_4321_aaaa_5555);
    isa_rev_level = 3'h2;
  endtask

  task automatic t_fpu();
    run(ins(OPC_FPU, FMT_MOVE_TO, 5'h2, 5'h6, 11'h0), 64'hc001_d00d_5eed_f00d,
        5'h04);
    chk("fpr wdata", fpr_wdata_q, 64'hc001_d00d_5eed_f00d);
    run(ins(OPC_FPU, FMT_MOVE_FROM, 5'h8, 5'h6, 11'h0), 64'h0,
        5'h10);
    chk("fpu rd", got, 64'hc001_d00d_5eed_f00d);
  endtask

  task automatic t_cus(input logic [3:0] w, input logic [15:0] s);
    cp2_wait = w;
    run(ins(OPC_CUS, FMT_MOVE_FROM, 5'ha, s[15:11], s[10:0]), 64'h0,
        5'h10);
    chk("cp2 spec", {48'h0, cp2_spec_q}, {48'h0, s});
    chk("cp2 rd", got, {4{s}} ^ 64'h0123_4567_89ab_cdef);
  endtask

  task automatic trap(input logic [31:0] i, input logic [2:0] cu,
    input logic o, p, input logic [4:0] e);
    cop_usable = cu;
    ops64_en = o;
    move_permit = p;
    run(i, 64'h0, e);
  endtask

  task automatic t_traps();
    trap(ins(OPC_SYS, FMT_MOVE_FROM, 5'h1, 5'h4, 11'h0), 3'h6, 1'b1, 1'b1,
         5'h02);
    chk("cop", {62'h0, exc_cop_q}, 64'h0);
    trap(ins(OPC_CUS, FMT_MOVE_FROM, 5'h1, 5'h0, 11'h0), 3'h3, 1'b1, 1'b1,
         5'h02);
    chk("cop", {62'h0, exc_cop_q}, 64'h2);
    trap(ins(OPC_FPU, FMT_MOVE_FROM, 5'h1, 5'h6, 11'h0), 3'h7, 1'b0, 1'b1,
         5'h01);
    trap(ins(OPC_FPU, FMT_MOVE_TO, 5'h1, 5'h6, 11'h0), 3'h7, 1'b1, 1'b0,
         5'h01);
    trap(ins(OPC_SYS, FMT_MOVE_TO, 5'h1, 5'h4, 11'h8), 3'h7, 1'b1, 1'b1,
         5'h01);
    trap(ins(OPC_FPU, FMT_MOVE_FROM, 5'h1, 5'h6, 11'h1), 3'h7, 1'b1, 1'b1,
         5'h01);
    // custom write is not one of the decoded moves
    trap(ins(OPC_CUS, FMT_MOVE_TO, 5'h1, 5'h0, 11'h0), 3'h7, 1'b1, 1'b1,
         5'h00);
  endtask

  // reset in the middle of a pending custom read
  task automatic t_rst();
    logic seen;
    seen = 1'b0;
    chk("rst out", {57'h0, busy_q, wb_valid_q, cp0_we_q, fpr_we_q, cp2_req_q,
        exc_cu_q, exc_ri_q}, 64'h0);
    cp2_wait = 4'h8;
    @(negedge clk_sys);
    instr = ins(OPC_CUS, FMT_MOVE_FROM, 5'h3, 5'h0, 11'h5);
    instr_valid = 1'b1;
    @(negedge clk_sys);
    instr_valid = 1'b0;
    @(negedge clk_sys);
    sys_rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    sys_rst = 1'b0;
    chk("rst busy", {63'h0, busy_q}, 64'h0);
    repeat (12)
    begin
      @(negedge clk_sys);
      seen = seen | wb_valid_q | busy_q;
    end
    chk("rst late valid", {63'h0, seen}, 64'h0);
  endtask

  task automatic results();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    #200000;
    n_errors++;
    results();
  end

  initial
  begin
    repeat (20) @(negedge clk_sys);
    sys_rst = 1'b0;
    t_rst();
    t_sys();
    t_fpu();
    t_cus(4'h0, 16'hffff);
    t_cus(4'h5, 16'h0001);
    t_traps();
    results();
  end
endmodule
